/* sim/ldw_sva.sv */
`timescale 1ns/100ps
module ldw_sva
  import ldw_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       lframe_n,
  input wire logic [3:0] lad_h_o,
  input wire logic       lad_h_oe,
  input wire logic [3:0] lad_p_o,
  input wire logic       lad_p_oe,
  input wire logic       ldrq_n,
  input wire logic [3:0] lad
);
  logic [2:0] rq_cnt_q;
  logic [3:0] ph_q;
  logic       tc_q;
  logic       rst_seen_q;
  wire        start_seen = !lframe_n && (lad == LDW_START);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Bit position inside a request frame, zero while the line idles
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rq_cnt_q <= 3'h0;
    end else if (rq_cnt_q == 3'h5) begin
      rq_cnt_q <= 3'h0;
    end else if (rq_cnt_q != 3'h0 || !ldrq_n) begin
      rq_cnt_q <= rq_cnt_q + 3'h1;
    end
  end

  // Field phase counted from START; wraps to idle after fifteen clocks
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_q <= 4'h0;
    end else if (start_seen) begin
      ph_q <= 4'h1;
    end else if (ph_q != 4'h0) begin
      ph_q <= ph_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tc_q <= 1'h0;
    end else if (ph_q == 4'h2) begin
      tc_q <= lad[3];
    end
  end

  // Set once a reset has really reached the flops; the edge at time zero may miss it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_seen_q <= 1'h1;
    end
  end

  a_rq_start_bit: assert property ($fell(ldrq_n) && rq_cnt_q == 3'h0 |-> ##4 ldrq_n)
    else $error("request frame lacks its active bit");
  a_rq_chan_msb: assert property (rq_cnt_q == 3'h1 |-> !ldrq_n)
    else $error("request channel out of range");
  a_rq_act_end: assert property (rq_cnt_q == 3'h4 |-> ldrq_n ##1 ldrq_n)
    else $error("request frame not closed by a high clock");
  a_host_start: assert property ($fell(lframe_n) |-> lad == LDW_START)
    else $error("frame opened without start value");
  a_host_type: assert property (ph_q == 4'h1 |-> lad[3:1] == {LDW_CT_DMA, LDW_DIR_WR})
    else $error("cycle type is not a DMA write");
  a_host_size: assert property (ph_q == 4'h3 |-> lad[1:0] == LDW_SIZE_8)
    else $error("size field is not one byte");
  a_host_tar: assert property (ph_q == 4'h4 |-> lad_h_oe && lad_h_o == LDW_TAR ##1 !lad_h_oe)
    else $error("host turnaround wrong");
  a_wait_four: assert property (ph_q == 4'h6 && lad_p_oe |->
    (lad == LDW_SYNC_WAIT)[*4] ##1 lad == (tc_q ? LDW_SYNC_LAST : LDW_SYNC_READY))
    else $error("wait states or sync code wrong");
  a_data_tar: assert property (ph_q == 4'hA && lad_p_oe |->
    lad_p_oe[*3] ##1 (lad_p_oe && lad_p_o == LDW_TAR) ##1 !lad_p_oe)
    else $error("data or peripheral turnaround wrong");
  a_quiet_unreq: assert property (ph_q == 4'h6 && !lad_p_oe |-> !lad_p_oe[*8])
    else $error("peripheral drove an ignored cycle");
  a_reset_quiet: assert property (disable iff (1'h0)
    !reset_n && rst_seen_q |-> ldrq_n && lframe_n && !lad_p_oe && !lad_h_oe)
    else $error("link not quiet during reset");
endmodule

/* sim/lpc_dma_write_8bit_target_tb.sv */
`timescale 1ns/100ps
module lpc_dma_write_8bit_target_tb;
  import ldw_pkg::*;
  logic       ref_clk;
  logic       reset_n;
  logic [3:0] dma_req;
  logic [7:0] data_i;
  logic [2:0] serv_chan_q;
  logic       byte_sent_q;
  logic       last_sent_q;
  logic [3:0] active_q;
  logic       go;
  logic [2:0] go_chan;
  logic       go_tc;
  logic       busy_q;
  logic [3:0] req_pend_q;
  logic       rx_valid_q;
  logic [7:0] rx_byte_q;
  logic [2:0] rx_chan_q;
  logic       rx_last_q;
  logic       rx_err_q;
  logic       rq_seen;
  int         fails;
  int         tests_run;

  ldw_if lif ();
  ldw_periph ldw_periph_i (.ref_clk(ref_clk), .reset_n(reset_n), .bus(lif), .dma_req(dma_req),
    .data_i(data_i), .serv_chan_q(serv_chan_q), .byte_sent_q(byte_sent_q),
    .last_sent_q(last_sent_q), .active_q(active_q));
  ldw_host ldw_host_i (.ref_clk(ref_clk), .reset_n(reset_n), .bus(lif), .go(go),
    .go_chan(go_chan), .go_tc(go_tc), .busy_q(busy_q), .req_pend_q(req_pend_q),
    .rx_valid_q(rx_valid_q), .rx_byte_q(rx_byte_q), .rx_chan_q(rx_chan_q),
    .rx_last_q(rx_last_q), .rx_err_q(rx_err_q));
  ldw_sva ldw_sva_i (.ref_clk(ref_clk), .reset_n(reset_n), .lframe_n(lif.lframe_n),
    .lad_h_o(lif.lad_h_o), .lad_h_oe(lif.lad_h_oe), .lad_p_o(lif.lad_p_o),
    .lad_p_oe(lif.lad_p_oe), .ldrq_n(lif.ldrq_n), .lad(lif.lad));

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Follows one request frame bit by bit; lim bounds the wait for its start bit
  task automatic watch_req(input logic [2:0] ch, input int lim);
    int n;
    n = 0;
    while (lif.ldrq_n !== 1'h0 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    chk({7'h0, lif.ldrq_n}, 8'h00);
    for (int i = 2; i >= 0; i--) begin
      @(negedge ref_clk);
      chk({7'h0, lif.ldrq_n}, {7'h0, ch[i]});
    end
    @(negedge ref_clk);
    chk({7'h0, lif.ldrq_n}, 8'h01);
    @(negedge ref_clk);
    chk({7'h0, lif.ldrq_n}, 8'h01);
    chk({6'h0, active_q[ch], req_pend_q[ch]}, 8'h03);
  endtask

  // One byte cycle; returns once the host is idle again
  task automatic dma_byte(input logic [2:0] ch, input logic tc, input logic [7:0] d,
                          input logic ok);
    int n;
    n = 0;
    data_i = d;
    go = 1'h1;
    go_chan = ch;
    go_tc = tc;
    rq_seen = 1'h0;
    @(negedge ref_clk);
    go = 1'h0;
    chk({6'h0, lif.lframe_n, busy_q}, 8'h01);
    while (rx_valid_q !== 1'h1 && rx_err_q !== 1'h1 && n < 30) begin
      @(negedge ref_clk);
      rq_seen |= !lif.ldrq_n;
      n++;
    end
    chk({7'h0, rx_err_q}, {7'h0, !ok});
    if (ok) begin
      chk(rx_byte_q, d);
      chk({5'h0, rx_chan_q}, {5'h0, ch});
      chk({5'h0, serv_chan_q}, {5'h0, ch});
      chk({5'h0, rx_last_q, last_sent_q, byte_sent_q}, {5'h0, tc, tc, 1'h1});
    end
    while (busy_q !== 1'h0 && n < 40) begin
      @(negedge ref_clk);
      rq_seen |= !lif.ldrq_n;
      n++;
    end
    chk({7'h0, busy_q}, 8'h00);
  endtask

  initial begin
    #300000;
    fails++;
    final_report();
  end

  initial begin
    reset_n = 1'h0;
    dma_req = 4'h0;
    data_i = 8'h00;
    go = 1'h0;
    go_chan = 3'h0;
    go_tc = 1'h0;
    rq_seen = 1'h0;
    fails = 0;
    tests_run = 0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({4'h0, lif.ldrq_n, lif.lframe_n, lif.lad_p_oe, lif.lad_h_oe}, 8'h0C);
    chk({4'h0, lif.lad}, 8'h0F);
    reset_n = 1'h1;
    dma_req = 4'hA;
    watch_req(3'h1, 4);
    watch_req(3'h3, 2);
    chk({active_q, req_pend_q}, 8'hAA);
    // Bytes of two channels interleave back to back
    dma_byte(3'h1, 1'h0, 8'hA5, 1'h1);
    dma_byte(3'h3, 1'h0, 8'h3C, 1'h1);
    dma_byte(3'h1, 1'h1, 8'hF0, 1'h1);
    chk({7'h0, rq_seen}, 8'h00);
    repeat (3) begin
      @(negedge ref_clk);
      chk({7'h0, lif.ldrq_n}, 8'h01);
    end
    watch_req(3'h1, 2);
    dma_req = 4'h2;
    dma_byte(3'h3, 1'h1, 8'h5A, 1'h1);
    dma_byte(3'h0, 1'h0, 8'h11, 1'h0);
    chk({active_q, req_pend_q}, 8'h22);
    final_report();
  end
endmodule

/* src/ldw_host.sv */
`timescale 1ns/100ps
module ldw_host
  import ldw_pkg::*;
#(
  parameter int NUM_CH = LDW_NUM_CH
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  ldw_if.host                    bus,
  input  wire logic              go,
  input  wire logic [2:0]        go_chan,
  input  wire logic              go_tc,
  output logic                   busy_q,
  output logic      [NUM_CH-1:0] req_pend_q,
  output logic                   rx_valid_q,
  output logic      [7:0]        rx_byte_q,
  output logic      [2:0]        rx_chan_q,
  output logic                   rx_last_q,
  output logic                   rx_err_q
);

  ldw_phase_t  st_q;
  ldw_phase_t  st_d;
  logic [3:0]  lad_o_q;
  logic [3:0]  lad_o_d;
  logic        lad_oe_q;
  logic        lad_oe_d;
  logic        lframe_n_q;
  logic        tc_q;
  logic        last_q;
  logic        dq_busy_q;
  logic [1:0]  dq_cnt_q;
  logic [2:0]  dq_ch_q;
  logic [2:0]  go_chan_q;

  wire logic [3:0] lad      = bus.lad;
  wire logic       sync_ok  = (lad == LDW_SYNC_READY) || (lad == LDW_SYNC_LAST);
  wire logic       sync_wt  = (lad == LDW_SYNC_WAIT);
  wire logic       dq_act   = dq_busy_q && (dq_cnt_q == 2'h3);
  wire logic       rx_fin   = (st_q == FS_DAT2) && last_q;

  assign bus.lframe_n = lframe_n_q;
  assign bus.lad_h_o  = lad_o_q;
  assign bus.lad_h_oe = lad_oe_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      FS_IDLE:  st_d = go ? FS_START : FS_IDLE;
      FS_START: st_d = FS_CT;
      FS_CT:    st_d = FS_CH;
      FS_CH:    st_d = FS_SZ;
      FS_SZ:    st_d = FS_TAR1;
      FS_TAR1:  st_d = FS_TAR2;
      FS_TAR2:  st_d = FS_WAIT;
      // No answer reads as pull-up 1111 and ends the cycle
      FS_WAIT:  st_d = sync_ok ? FS_DAT1 : (sync_wt ? FS_WAIT : FS_IDLE);
      FS_DAT1:  st_d = FS_DAT2;
      FS_DAT2:  st_d = FS_PTAR1;
      FS_PTAR1: st_d = FS_PTAR2;
      default:  st_d = FS_IDLE;
    endcase
  end

  always_comb begin
    lad_oe_d = 1'b1;
    lad_o_d  = LDW_TAR;
    case (st_d)
      FS_START: lad_o_d = LDW_START;
      FS_CT:    lad_o_d = {LDW_CT_DMA, LDW_DIR_WR, 1'b0};
      FS_CH:    lad_o_d = {tc_q, go_chan_q};
      FS_SZ:    lad_o_d = {2'h0, LDW_SIZE_8};
      FS_TAR1:  lad_o_d = LDW_TAR;
      default:  lad_oe_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q       <= FS_IDLE;
      lad_oe_q   <= 1'b0;
      lad_o_q    <= LDW_TAR;
      lframe_n_q <= 1'b1;
      busy_q     <= 1'b0;
    end else begin
      st_q       <= st_d;
      lad_oe_q   <= lad_oe_d;
      lad_o_q    <= lad_o_d;
      lframe_n_q <= (st_d != FS_START);
      busy_q     <= (st_d != FS_IDLE);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      go_chan_q <= 3'h0;
      tc_q      <= 1'b0;
      last_q    <= 1'b0;
      rx_byte_q <= 8'h00;
      rx_chan_q <= 3'h0;
    end else begin
      if (st_q == FS_IDLE && go) begin
        go_chan_q <= go_chan;
        tc_q      <= go_tc;
      end
      if (st_q == FS_WAIT) begin
        last_q <= (lad == LDW_SYNC_LAST);
      end
      if (st_q == FS_DAT1) begin
        rx_byte_q[3:0] <= lad;
        rx_chan_q      <= go_chan_q;
      end
      if (st_q == FS_DAT2) begin
        rx_byte_q[7:4] <= lad;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_valid_q <= 1'b0;
      rx_last_q  <= 1'b0;
      rx_err_q   <= 1'b0;
    end else begin
      rx_valid_q <= (st_q == FS_DAT2);
      rx_last_q  <= rx_fin;
      rx_err_q   <= (st_q == FS_WAIT) && !sync_ok && !sync_wt;
    end
  end

  // Request decoder; the trailing high clock needs no state of its own
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dq_busy_q <= 1'b0;
      dq_cnt_q  <= 2'h0;
      dq_ch_q   <= 3'h0;
    end else if (!dq_busy_q) begin
      dq_cnt_q  <= 2'h0;
      dq_busy_q <= (bus.ldrq_n == LDW_RQ_START);
    end else begin
      dq_cnt_q <= dq_cnt_q + 2'h1;
      if (dq_cnt_q != 2'h3) begin
        dq_ch_q <= {dq_ch_q[1:0], bus.ldrq_n};
      end else begin
        dq_busy_q <= 1'b0;
      end
    end
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_pend
    wire logic hit_i = dq_act && (dq_ch_q == 3'(i));

    // A new request in the clock of the final byte wins over its clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        req_pend_q[i] <= 1'b0;
      end else if (hit_i) begin
        req_pend_q[i] <= (bus.ldrq_n == LDW_RQ_ACT);
      end else if (rx_fin && go_chan_q == 3'(i)) begin
        req_pend_q[i] <= 1'b0;
      end
    end
  end

endmodule

/* src/ldw_if.sv */
`timescale 1ns/100ps
interface ldw_if;
  logic       lframe_n;
  logic [3:0] lad_h_o;
  logic       lad_h_oe;
  logic [3:0] lad_p_o;
  logic       lad_p_oe;
  logic       ldrq_n;
  logic [3:0] lad;

  // Undriven data lines float high through the board pull-ups
  assign lad = lad_p_oe ? lad_p_o : (lad_h_oe ? lad_h_o : ldw_pkg::LDW_PULL_UP);

  modport periph (
    input  lframe_n,
    input  lad,
    output lad_p_o,
    output lad_p_oe,
    output ldrq_n
  );

  modport host (
    input  lad,
    input  ldrq_n,
    output lframe_n,
    output lad_h_o,
    output lad_h_oe
  );
endinterface

/* src/ldw_periph.sv */
// Summary of operation
// - Request starts with a zero start bit
// - Then three channel bits, MSB first
// - Then active bit one, then one high clock
// - New request only after that high clock
// - Eight clocks no request after final sync; code holds off only the channel that got it
// - Host opens each byte with START 0000
// - Host sends cycle type 101x, DMA write
// - Channel field acknowledges, bit3 zero means more
// - Bit3 one marks terminal count, final byte
// - Host size field selects one byte
// - Host drives TAR 1111 then releases
// - Non-final byte answers sync 1001
// - Final byte answers sync 0000
// - Two data nibbles follow the sync
// - Peripheral drives 1111, then releases LAD
// - Exactly four 0101 wait states first
// - Byte cycles may be interleaved with others
// - Peripheral is the data source
// - Reset: ignore frame, release LAD, request high
`timescale 1ns/100ps
module ldw_periph
  import ldw_pkg::*;
#(
  parameter int NUM_CH = LDW_NUM_CH
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  ldw_if.periph                  bus,
  input  wire logic [NUM_CH-1:0] dma_req,
  input  wire logic [7:0]        data_i,
  output logic      [2:0]        serv_chan_q,
  output logic                   byte_sent_q,
  output logic                   last_sent_q,
  output logic      [NUM_CH-1:0] active_q
);

  ldw_phase_t       st_q;
  ldw_phase_t       st_d;
  logic [2:0]       wcnt_q;
  logic             tc_q;
  logic [7:0]       data_q;
  logic [3:0]       lad_o_q;
  logic [3:0]       lad_o_d;
  logic             lad_oe_q;
  logic             lad_oe_d;

  logic             rq_busy_q;
  logic [2:0]       rq_cnt_q;
  logic [2:0]       rq_ch_q;
  logic             ldrq_n_q;
  logic [2:0]       pick;
  logic [3:0]       hold_q [NUM_CH];
  logic [NUM_CH-1:0] want;

  wire logic [3:0]  lad       = bus.lad;
  wire logic [7:0]  act8      = 8'(active_q);
  wire logic        ch_hit    = act8[lad[2:0]];
  wire logic        ct_ok     = (lad[3:2] == LDW_CT_DMA) && (lad[1] == LDW_DIR_WR);
  wire logic        sz_ok     = (lad[1:0] == LDW_SIZE_8);
  wire logic        wait_done = (wcnt_q == 3'(LDW_WAIT_N - 1));
  wire logic        last_evt  = (st_q == FS_SYNC) && tc_q;
  wire logic        rq_done   = rq_busy_q && (rq_cnt_q == 3'(LDW_RQ_LAST));
  wire logic        rq_go     = !rq_busy_q && (|want);

  assign bus.lad_p_o  = lad_o_q;
  assign bus.lad_p_oe = lad_oe_q;
  assign bus.ldrq_n   = ldrq_n_q;

  // Field tracker; a frame strobe always restarts it, which also covers aborts
  always_comb begin
    st_d = st_q;
    if (!bus.lframe_n) begin
      st_d = (lad == LDW_START) ? FS_CT : FS_IDLE;
    end else begin
      case (st_q)
        FS_CT:    st_d = ct_ok ? FS_CH : FS_IDLE;
        FS_CH:    st_d = ch_hit ? FS_SZ : FS_IDLE;
        FS_SZ:    st_d = sz_ok ? FS_TAR1 : FS_IDLE;
        FS_TAR1:  st_d = FS_TAR2;
        FS_TAR2:  st_d = FS_WAIT;
        FS_WAIT:  st_d = wait_done ? FS_SYNC : FS_WAIT;
        FS_SYNC:  st_d = FS_DAT1;
        FS_DAT1:  st_d = FS_DAT2;
        FS_DAT2:  st_d = FS_PTAR1;
        FS_PTAR1: st_d = FS_IDLE;
        default:  st_d = FS_IDLE;
      endcase
    end
  end

  // Drive values follow the next phase so the pins line up with st_q
  always_comb begin
    lad_oe_d = 1'b1;
    lad_o_d  = LDW_TAR;
    case (st_d)
      FS_WAIT:  lad_o_d = LDW_SYNC_WAIT;
      FS_SYNC:  lad_o_d = tc_q ? LDW_SYNC_LAST : LDW_SYNC_READY;
      FS_DAT1:  lad_o_d = data_q[3:0];
      FS_DAT2:  lad_o_d = data_q[7:4];
      FS_PTAR1: lad_o_d = LDW_TAR;
      default:  lad_oe_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q     <= FS_IDLE;
      lad_oe_q <= 1'b0;
      lad_o_q  <= LDW_TAR;
    end else begin
      st_q     <= st_d;
      lad_oe_q <= lad_oe_d;
      lad_o_q  <= lad_o_d;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wcnt_q <= 3'h0;
    end else if (st_q == FS_WAIT) begin
      wcnt_q <= wcnt_q + 3'h1;
    end else begin
      wcnt_q <= 3'h0;
    end
  end

  // Channel and terminal count held from the acknowledge field
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      serv_chan_q <= 3'h0;
      tc_q        <= 1'b0;
    end else if (st_q == FS_CH && bus.lframe_n && ch_hit) begin
      serv_chan_q <= lad[2:0];
      tc_q        <= lad[3];
    end
  end

  // Byte is sampled on the last wait clock, giving the source the whole wait
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= 8'h00;
    end else if (st_q == FS_WAIT && wait_done) begin
      data_q <= data_i;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_sent_q <= 1'b0;
      last_sent_q <= 1'b0;
    end else begin
      byte_sent_q <= (st_q == FS_DAT2) && bus.lframe_n;
      last_sent_q <= (st_q == FS_DAT2) && bus.lframe_n && tc_q;
    end
  end

  // Lowest eligible channel wins the request line
  always_comb begin
    pick = 3'h0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (want[k]) begin
        pick = 3'(k);
      end
    end
  end

  // Serial request: start, three channel bits, active, then one high clock
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rq_busy_q <= 1'b0;
      rq_cnt_q  <= 3'h0;
      rq_ch_q   <= 3'h0;
      ldrq_n_q  <= LDW_RQ_IDLE;
    end else if (!rq_busy_q) begin
      rq_cnt_q <= 3'h0;
      if (rq_go) begin
        rq_busy_q <= 1'b1;
        rq_ch_q   <= pick;
        ldrq_n_q  <= LDW_RQ_START;
      end else begin
        ldrq_n_q  <= LDW_RQ_IDLE;
      end
    end else begin
      rq_cnt_q <= rq_cnt_q + 3'h1;
      case (rq_cnt_q)
        3'h0:    ldrq_n_q <= rq_ch_q[2];
        3'h1:    ldrq_n_q <= rq_ch_q[1];
        3'h2:    ldrq_n_q <= rq_ch_q[0];
        3'h3:    ldrq_n_q <= LDW_RQ_ACT;
        default: ldrq_n_q <= LDW_RQ_IDLE;
      endcase
      if (rq_done) begin
        rq_busy_q <= 1'b0;
      end
    end
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    wire logic fin_i = last_evt && (serv_chan_q == 3'(i));
    wire logic arm_i = rq_done && (rq_ch_q == 3'(i));

    assign want[i] = dma_req[i] && !active_q[i] && (hold_q[i] == 4'h0);

    // Hold-off after the final sync; a channel is only rearmed once it runs out
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        hold_q[i]   <= 4'h0;
        active_q[i] <= 1'b0;
      end else begin
        if (fin_i) begin
          hold_q[i]   <= 4'(LDW_HOLDOFF);
          active_q[i] <= 1'b0;
        end else begin
          if (hold_q[i] != 4'h0) begin
            hold_q[i] <= hold_q[i] - 4'h1;
          end
          if (arm_i) begin
            active_q[i] <= 1'b1;
          end
        end
      end
    end
  end

endmodule

/* src/ldw_pkg.sv */
package ldw_pkg;

  // Link field values
  localparam logic [3:0] LDW_START      = 4'h0;
  localparam logic [1:0] LDW_CT_DMA     = 2'h2;
  localparam logic       LDW_DIR_WR     = 1'b1;
  localparam logic [1:0] LDW_SIZE_8     = 2'h0;
  localparam logic [3:0] LDW_TAR        = 4'hF;
  localparam logic [3:0] LDW_SYNC_WAIT  = 4'h5;
  localparam logic [3:0] LDW_SYNC_READY = 4'h9;
  localparam logic [3:0] LDW_SYNC_LAST  = 4'h0;
  localparam logic [3:0] LDW_PULL_UP    = 4'hF;

  // Request line levels
  localparam logic       LDW_RQ_START   = 1'b0;
  localparam logic       LDW_RQ_ACT     = 1'b1;
  localparam logic       LDW_RQ_IDLE    = 1'b1;

  // Channel count, then counts in link clocks
  localparam int         LDW_NUM_CH     = 4;
  localparam int         LDW_WAIT_N     = 4;
  localparam int         LDW_HOLDOFF    = 8;
  localparam int         LDW_RQ_LAST    = 4;

  // One shared set of field phases; each end uses the ones it needs
  typedef enum logic [3:0] {
    FS_IDLE  = 4'b0000,
    FS_START = 4'b0001,
    FS_CT    = 4'b0010,
    FS_CH    = 4'b0011,
    FS_SZ    = 4'b0100,
    FS_TAR1  = 4'b0101,
    FS_TAR2  = 4'b0110,
    FS_WAIT  = 4'b0111,
    FS_SYNC  = 4'b1000,
    FS_DAT1  = 4'b1001,
    FS_DAT2  = 4'b1010,
    FS_PTAR1 = 4'b1011,
    FS_PTAR2 = 4'b1100
  } ldw_phase_t;

endpackage
